// ===== core/bpm_pkg.sv
/*
  Shared constants, register map and carrier types for the low-byte and strobe port
  pin multiplexer.
  Assumes a classic Wishbone slave with 32-bit data and byte addressing. Mode, bus width
  and DRAM area settings arrive as levels from the bus controller and mode straps.
*/
// What this block does
// RULE1 - Full expanded modes: low-byte pins are GPIO if all 8-bit, data bus if 16-bit
// RULE2 - Modes 3/7: expansion off gives GPIO, expansion on follows bus width choice
// RULE3 - Low-byte pull-up on only in 8-bit mode, direction 0 and pull-up bit 1
// RULE4 - Strobe port direction register is write-only; reads return a fixed filler
// RULE5 - Clock pin direction resets to 1 in modes 1,2,4,5,6, else 0; others 0
// RULE6 - Top strobe pin drives system clock when its direction is 1, else input
// RULE7 - Address strobe pin outputs strobe when expanded and its enable is set
// RULE8 - Read and high write strobe pins are bus outputs whenever expanded
// RULE9 - Low write strobe pin outputs strobe when expanded and its enable is set
// RULE10 - Lower column pin outputs strobe when any DRAM area of 2 to 5 is 16-bit
// RULE11 - Column strobe pins feed interrupt 15 and 14 while their select bit is 0
// RULE12 - Upper column pin outputs strobe when any of areas 2 to 5 is DRAM
// RULE13 - Wait pin is the wait input when expanded and wait enable is 1
// RULE14 - Strobe port data register is read/write, resets 0, drives GPIO outputs
// RULE15 - Pin level register reads data bit for outputs, pin for inputs; writes ignored
// RULE16 - In modes 3/7 expanded, lowest three strobe pins need function select bits
// RULE17 - Modes 3/7 with expansion off: pins 6 to 0 are plain GPIO
// RULE18 - Low-byte GPIO: direction 1 is output, 0 is input
// RULE19 - Bus function overrides GPIO output in the same cycle the selection changes
package bpm_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PF_DIR   = 8'h00;
  localparam logic [7:0] OFS_PF_DATA  = 8'h04;
  localparam logic [7:0] OFS_PF_PIN   = 8'h08;
  localparam logic [7:0] OFS_PE_DIR   = 8'h0C;
  localparam logic [7:0] OFS_PE_DATA  = 8'h10;
  localparam logic [7:0] OFS_PE_PIN   = 8'h14;
  localparam logic [7:0] OFS_PE_PULL  = 8'h18;
  localparam logic [7:0] OFS_CTRL     = 8'h1C;
  localparam logic [7:0] OFS_FSEL     = 8'h20;

  // ----------------------------------------------------------------
  // Reset values and read filler
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [2:0] RST_FSEL     = 3'h0;
  localparam logic [7:0] UNDEF_READ   = 8'hA5;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_EXPANSION = 0;
  localparam int CTL_AS_OE     = 1;
  localparam int CTL_LWR_OE    = 2;
  localparam int CTL_WAIT_EN   = 3;
  localparam int CTL_INTERRUPT_REQUEST_14_SEL = 4;
  localparam int CTL_INTERRUPT_REQUEST_15_SEL = 5;

  // Function select fields, used in modes 3 and 7
  localparam int FS_LOWER_COLUMN_STROBE = 0;
  localparam int FS_UPPER_COLUMN_STROBE = 1;
  localparam int FS_WAIT = 2;

  // Strobe port pin positions
  localparam int PIN_WAIT = 0;
  localparam int PIN_UPPER_COLUMN_STROBE = 1;
  localparam int PIN_LOWER_COLUMN_STROBE = 2;
  localparam int PIN_LWR  = 3;
  localparam int PIN_HWR  = 4;
  localparam int PIN_RD   = 5;
  localparam int PIN_AS   = 6;
  localparam int PIN_CLK  = 7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sys_clock;
    logic address_strobe;
    logic read_strobe;
    logic high_write_strobe;
    logic low_write_strobe;
    logic lower_column_strobe;
    logic upper_column_strobe;
  } bpm_strobes_t;

  typedef struct packed {
    logic [7:0] pf_dir;
    logic [7:0] pf_dr;
    logic [7:0] pe_dir;
    logic [7:0] pe_dr;
    logic [7:0] pe_pcr;
    logic [7:0] ctrl;
    logic [2:0] fsel;
    logic       ack;
    logic [7:0] rdata;
    logic       init_done;
  } bpm_state_t;

  // Modes 1, 2, 4, 5 and 6 are always expanded
  function automatic logic bpm_full_expanded(input logic [2:0] mode);
    case (mode)
      3'h1, 3'h2, 3'h4, 3'h5, 3'h6: bpm_full_expanded = 1'b1;
      default:                      bpm_full_expanded = 1'b0;
    endcase
  endfunction

  // Output pins read back their data bit, inputs the live pin
  function automatic logic [7:0] bpm_pin_read(input logic [7:0] dir,
                                              input logic [7:0] dr,
                                              input logic [7:0] pin);
    bpm_pin_read = (dir & dr) | (~dir & pin);
  endfunction

endpackage

// ===== core/bpm_port_mux.sv
/*
  Pin multiplexer and GPIO for the low data byte port and the strobe port, with a
  Wishbone classic register slave.
  Assumes pin inputs are synchronous to clock; mode is stable from reset release.
*/
module bpm_port_mux (
  // Clock and reset
  input  wire  logic                 clock,
  input  wire  logic                 reset,
  // Wishbone slave
  input  wire  logic                 wb_cyc_i,
  input  wire  logic                 wb_stb_i,
  input  wire  logic                 wb_we_i,
  input  wire  logic [7:0]           wb_adr_i,
  input  wire  logic [3:0]           wb_sel_i,
  input  wire  logic [31:0]          wb_dat_i,
  output logic       [31:0]          wb_dat_o,
  output logic                       wb_ack_o,
  // Mode and bus controller settings
  input  wire  logic [2:0]           mode,
  input  wire  logic [7:0]           area_16bit,
  input  wire  logic [3:0]           dram_area_mask,
  // Bus controller signals
  input  wire  bpm_pkg::bpm_strobes_t strobes,
  input  wire  logic [7:0]           data_low_out,
  input  wire  logic                 data_low_oe,
  output logic       [7:0]           data_low_in,
  output logic                       wait_request,
  output logic                       interrupt_request_15,
  output logic                       interrupt_request_14,
  // Low-byte port pins
  input  wire  logic [7:0]           pe_in,
  output logic       [7:0]           pe_out,
  output logic       [7:0]           pe_oe,
  output logic       [7:0]           pe_pullup,
  // Strobe port pins
  input  wire  logic [7:0]           pf_in,
  output logic       [7:0]           pf_out,
  output logic       [7:0]           pf_oe
);
  import bpm_pkg::*;

  bpm_state_t s_reg;
  bpm_state_t s_next;

  logic full_mode;
  logic expanded;
  logic bus16;
  logic as_en;
  logic lwr_en;
  logic lower_column_strobe_en;
  logic upper_column_strobe_en;
  logic wait_en;
  logic req;
  logic wr;
  logic [7:0] adr;

  // ----------------------------------------------------------------
  // Function selection
  // ----------------------------------------------------------------
  assign full_mode = bpm_full_expanded(mode);
  assign expanded  = full_mode | s_reg.ctrl[CTL_EXPANSION];  // RULE2
  assign bus16     = expanded & (|area_16bit);                // RULE1 RULE2
  assign as_en     = expanded & s_reg.ctrl[CTL_AS_OE];        // RULE7
  assign lwr_en    = expanded & s_reg.ctrl[CTL_LWR_OE];       // RULE9
  assign lower_column_strobe_en   = expanded & (full_mode | s_reg.fsel[FS_LOWER_COLUMN_STROBE])
                   & (|(dram_area_mask & area_16bit[5:2]));   // RULE10 RULE16
  assign upper_column_strobe_en   = expanded & (full_mode | s_reg.fsel[FS_UPPER_COLUMN_STROBE])
                   & (|dram_area_mask);                       // RULE12 RULE16
  assign wait_en   = expanded & (full_mode | s_reg.fsel[FS_WAIT])
                   & s_reg.ctrl[CTL_WAIT_EN];                 // RULE13 RULE16

  // ----------------------------------------------------------------
  // Low-byte port pins
  // ----------------------------------------------------------------
  always_comb begin
    if (bus16) begin
      pe_out = data_low_out;                                  // RULE1 RULE19
      pe_oe  = {8{data_low_oe}};
    end else begin
      pe_out = s_reg.pe_dr;                                   // RULE18
      pe_oe  = s_reg.pe_dir;                                  // RULE18
    end
  end
  assign pe_pullup   = (~|area_16bit) ? (~s_reg.pe_dir & s_reg.pe_pcr) : 8'h00;  // RULE3
  assign data_low_in = pe_in;

  // ----------------------------------------------------------------
  // Strobe port pins
  // ----------------------------------------------------------------
  always_comb begin
    pf_out = s_reg.pf_dr;                                     // RULE14 RULE17
    pf_oe  = s_reg.pf_dir;                                    // RULE17
    if (s_reg.pf_dir[PIN_CLK]) begin
      pf_out[PIN_CLK] = strobes.sys_clock;                    // RULE6
    end
    if (as_en) begin
      pf_out[PIN_AS] = strobes.address_strobe;                // RULE7 RULE19
      pf_oe[PIN_AS]  = 1'b1;
    end
    if (expanded) begin
      pf_out[PIN_RD]  = strobes.read_strobe;                  // RULE8
      pf_oe[PIN_RD]   = 1'b1;
      pf_out[PIN_HWR] = strobes.high_write_strobe;            // RULE8
      pf_oe[PIN_HWR]  = 1'b1;
    end
    if (lwr_en) begin
      pf_out[PIN_LWR] = strobes.low_write_strobe;             // RULE9
      pf_oe[PIN_LWR]  = 1'b1;
    end
    if (lower_column_strobe_en) begin
      pf_out[PIN_LOWER_COLUMN_STROBE] = strobes.lower_column_strobe;         // RULE10
      pf_oe[PIN_LOWER_COLUMN_STROBE]  = 1'b1;
    end
    if (upper_column_strobe_en) begin
      pf_out[PIN_UPPER_COLUMN_STROBE] = strobes.upper_column_strobe;         // RULE12
      pf_oe[PIN_UPPER_COLUMN_STROBE]  = 1'b1;
    end
    if (wait_en) begin
      pf_out[PIN_WAIT] = 1'b0;                                // RULE13
      pf_oe[PIN_WAIT]  = 1'b0;
    end
  end

  // Interrupt inputs tap the pins alongside any port function
  assign interrupt_request_15 = ~s_reg.ctrl[CTL_INTERRUPT_REQUEST_15_SEL] & pf_in[PIN_LOWER_COLUMN_STROBE];  // RULE11
  assign interrupt_request_14 = ~s_reg.ctrl[CTL_INTERRUPT_REQUEST_14_SEL] & pf_in[PIN_UPPER_COLUMN_STROBE];  // RULE11
  assign wait_request         = wait_en & pf_in[PIN_WAIT];                     // RULE13

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i;
  assign wr  = req & wb_we_i & s_reg.ack & wb_sel_i[0];
  assign adr = {wb_adr_i[7:2], 2'b00};

  always_comb begin
    s_next     = s_reg;
    s_next.ack = req & ~s_reg.ack;
    // Mode dependent clock pin direction is loaded once after release
    if (!s_reg.init_done) begin
      s_next.init_done      = 1'b1;
      s_next.pf_dir[PIN_CLK] = full_mode;                     // RULE5
    end
    if (req & ~s_reg.ack & ~wb_we_i) begin
      case (adr)
        OFS_PF_DIR:  s_next.rdata = UNDEF_READ;               // RULE4
        OFS_PF_DATA: s_next.rdata = s_reg.pf_dr;              // RULE14
        OFS_PF_PIN:  s_next.rdata = bpm_pin_read(s_reg.pf_dir, s_reg.pf_dr, pf_in);  // RULE15
        OFS_PE_DIR:  s_next.rdata = UNDEF_READ;
        OFS_PE_DATA: s_next.rdata = s_reg.pe_dr;
        OFS_PE_PIN:  s_next.rdata = bpm_pin_read(s_reg.pe_dir, s_reg.pe_dr, pe_in);
        OFS_PE_PULL: s_next.rdata = s_reg.pe_pcr;
        OFS_CTRL:    s_next.rdata = s_reg.ctrl;
        OFS_FSEL:    s_next.rdata = {5'h00, s_reg.fsel};
        default:     s_next.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      case (adr)
        OFS_PF_DIR:  s_next.pf_dir = wb_dat_i[7:0];
        OFS_PF_DATA: s_next.pf_dr  = wb_dat_i[7:0];           // RULE14
        OFS_PE_DIR:  s_next.pe_dir = wb_dat_i[7:0];
        OFS_PE_DATA: s_next.pe_dr  = wb_dat_i[7:0];
        OFS_PE_PULL: s_next.pe_pcr = wb_dat_i[7:0];
        OFS_CTRL:    s_next.ctrl   = wb_dat_i[7:0];
        OFS_FSEL:    s_next.fsel   = wb_dat_i[2:0];
        default:     s_next.fsel   = s_reg.fsel;              // RULE15
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_reg.pf_dir    <= RST_BYTE;                            // RULE5
      s_reg.pf_dr     <= RST_BYTE;                            // RULE14
      s_reg.pe_dir    <= RST_BYTE;
      s_reg.pe_dr     <= RST_BYTE;
      s_reg.pe_pcr    <= RST_BYTE;
      s_reg.ctrl      <= RST_BYTE;
      s_reg.fsel      <= RST_FSEL;
      s_reg.ack       <= 1'b0;
      s_reg.rdata     <= RST_BYTE;
      s_reg.init_done <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = {24'h000000, s_reg.rdata};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_rule1;
    full_mode && (area_16bit == 8'h00) |-> (pe_oe == s_reg.pe_dir) && (pe_out == s_reg.pe_dr);
  endproperty
  a_rule1: assert property (p_rule1) else $error("low byte not GPIO in 8-bit mode"); // RULE1

  property p_rule2;
    !full_mode && !s_reg.ctrl[CTL_EXPANSION] |-> pe_oe == s_reg.pe_dir;
  endproperty
  a_rule2: assert property (p_rule2) else $error("low byte not GPIO, expansion off"); // RULE2

  property p_rule3;
    (|area_16bit) |-> pe_pullup == 8'h00;
  endproperty
  a_rule3: assert property (p_rule3) else $error("pull-up on in 16-bit mode"); // RULE3

  property p_rule4;
    req && !wb_we_i && !s_reg.ack && adr == OFS_PF_DIR |=> wb_ack_o && wb_dat_o[7:0] == UNDEF_READ;
  endproperty
  a_rule4: assert property (p_rule4) else $error("direction read not filler"); // RULE4

  property p_rule5;
    $rose(s_reg.init_done) |-> s_reg.pf_dir[PIN_CLK] == full_mode && s_reg.pf_dir[6:0] == 7'h00;
  endproperty
  a_rule5: assert property (p_rule5) else $error("clock pin direction wrong at init"); // RULE5

  property p_rule6;
    s_reg.pf_dir[PIN_CLK] |-> pf_oe[PIN_CLK] && pf_out[PIN_CLK] == strobes.sys_clock;
  endproperty
  a_rule6: assert property (p_rule6) else $error("clock output missing"); // RULE6

  property p_rule8;
    full_mode |-> pf_oe[PIN_RD] && pf_oe[PIN_HWR] && pf_out[PIN_RD] == strobes.read_strobe;
  endproperty
  a_rule8: assert property (p_rule8) else $error("read strobe not driven"); // RULE8

  property p_rule12;
    full_mode && (|dram_area_mask) |-> pf_oe[PIN_UPPER_COLUMN_STROBE] &&
      pf_out[PIN_UPPER_COLUMN_STROBE] == strobes.upper_column_strobe;
  endproperty
  a_rule12: assert property (p_rule12) else $error("upper column strobe not driven"); // RULE12

  property p_rule11;
    !s_reg.ctrl[CTL_INTERRUPT_REQUEST_15_SEL] |-> interrupt_request_15 == pf_in[PIN_LOWER_COLUMN_STROBE];
  endproperty
  a_rule11: assert property (p_rule11) else $error("interrupt 15 not fed"); // RULE11

  property p_rule14;
    wr && adr == OFS_PF_DATA |=> s_reg.pf_dr == $past(wb_dat_i[7:0]);
  endproperty
  a_rule14: assert property (p_rule14) else $error("data register write lost"); // RULE14

  property p_rule15;
    wr && adr == OFS_PF_PIN |=> $stable(s_reg.pf_dr) && $stable(s_reg.pf_dir);
  endproperty
  a_rule15: assert property (p_rule15) else $error("pin register write took effect"); // RULE15

  property p_rule17;
    !full_mode && !s_reg.ctrl[CTL_EXPANSION] |-> pf_oe[6:0] == s_reg.pf_dir[6:0];
  endproperty
  a_rule17: assert property (p_rule17) else $error("strobe port not GPIO"); // RULE17

  property p_ack;
    req && !s_reg.ack |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single cycle pulse");

  c_write: cover property (wr && adr == OFS_PF_DATA);
  c_read:  cover property (wb_ack_o && !wb_we_i && adr == OFS_PF_PIN);
  c_bus16: cover property (bus16 && data_low_oe);
  c_wait:  cover property (wait_en && wait_request);

endmodule

// ===== verification/bpm_pin_partner.sv
/*
  Far-side model of the port pins: memory and peripherals on the expansion bus.
  Assumes the block raises an output enable while it drives a pin; the bench
  chooses what the far side drives on the other lines.
*/
module bpm_pin_partner (
  // Clock
  input  wire logic       clock,
  // Block side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  // Far-side drive
  input  wire logic [7:0] far_val,
  input  wire logic [7:0] far_en,
  // Resolved pin level
  output logic      [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] float_reg = 8'h55;

  // Undriven lines without pull-up wander, so a stale level never passes for data
  always @(posedge clock) float_reg <= ~float_reg;

  assign pin_level = (pin_oe & pin_out) | (~pin_oe & far_en & far_val)
                   | (~pin_oe & ~far_en & (pin_pullup | float_reg));
endmodule

// ===== verification/test_bpm_port_mux.sv
/*
  Self-checking bench for the port pin multiplexer.
  Assumes the Wishbone slave and register map of bpm_pkg; far side is bpm_pin_partner.
*/
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module test_bpm_port_mux;
  timeunit 1ns;
  timeprecision 1ps;
  import bpm_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic         clock = 1'b0, reset = 1'b1;
  logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]   wb_adr_i = 8'h00;
  logic [3:0]   wb_sel_i = 4'h0;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o;
  logic [2:0]   mode = 3'h1;
  logic [7:0]   area_16bit = 8'h00;
  logic [3:0]   dram_area_mask = 4'h0;
  bpm_strobes_t strobes = 7'h56;
  logic         data_low_oe = 1'b0, wait_request, interrupt_request_15, interrupt_request_14;
  logic [7:0]   data_low_out = 8'hC3, data_low_in, pe_in, pe_out, pe_oe, pe_pullup;
  logic [7:0]   pf_in, pf_out, pf_oe, rd;
  logic [7:0]   pe_far = 8'h00, pe_far_en = 8'h00, pf_far = 8'h00, pf_far_en = 8'h00;
  int           fail_count = 0, total_checks = 0;

  always #2.5 clock = ~clock;

  bpm_port_mux u_dut (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode(mode), .area_16bit(area_16bit),
    .dram_area_mask(dram_area_mask), .strobes(strobes), .data_low_out(data_low_out),
    .data_low_oe(data_low_oe), .data_low_in(data_low_in), .wait_request(wait_request),
    .interrupt_request_15(interrupt_request_15), .interrupt_request_14(interrupt_request_14),
    .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe), .pe_pullup(pe_pullup),
    .pf_in(pf_in), .pf_out(pf_out), .pf_oe(pf_oe));

  bpm_pin_partner u_pe_far (.clock(clock), .pin_out(pe_out), .pin_oe(pe_oe),
    .pin_pullup(pe_pullup), .far_val(pe_far), .far_en(pe_far_en), .pin_level(pe_in));
  bpm_pin_partner u_pf_far (.clock(clock), .pin_out(pf_out), .pin_oe(pf_oe),
    .pin_pullup(8'h00), .far_val(pf_far), .far_en(pf_far_en), .pin_level(pf_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task close_out;
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One classic cycle; returns where pins already show the write
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    n = 0;
    // Ack and read data are taken at the rising edge, before the slave updates
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      close_out();
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(negedge clock);
  endtask

  task do_reset(input logic [2:0] m);
    @(posedge clock);
    reset <= 1'b1;
    mode  <= m;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset_mode1;
    do_reset(3'h1);
    `CHK("pf_oe reset", 8'hB0, pf_oe)
    `CHK("clock pin", strobes.sys_clock, pf_out[7])
    wb(1'b0, OFS_PF_DIR, 8'h00);
    `CHK("dir read", UNDEF_READ, rd)
    `CHK("dat upper", 24'h000000, wb_dat_o[31:8])
    wb(1'b0, OFS_PF_DATA, 8'h00);
    `CHK("data reset", RST_BYTE, rd)
    wb(1'b1, 8'h3C, 8'hFF);
    wb(1'b0, 8'h3C, 8'h00);
    `CHK("unmapped", 8'h00, rd)
  endtask

  task t_low_byte_mode1;
    wb(1'b1, OFS_PE_DIR, 8'h0F);
    wb(1'b1, OFS_PE_DATA, 8'h05);
    wb(1'b1, OFS_PE_PULL, 8'hFF);
    `CHK("pe_oe", 8'h0F, pe_oe)
    `CHK("pe_out", 4'h5, pe_out[3:0])
    `CHK("pe_pullup", 8'hF0, pe_pullup)
    @(posedge clock);
    area_16bit  <= 8'h01;
    data_low_oe <= 1'b1;
    @(negedge clock);
    `CHK("pe bus oe", 8'hFF, pe_oe)
    `CHK("pe bus out", data_low_out, pe_out)
    `CHK("pe pull 16", 8'h00, pe_pullup)
    @(posedge clock);
    data_low_oe <= 1'b0;
    pe_far      <= 8'h69;
    pe_far_en   <= 8'hFF;
    @(negedge clock);
    `CHK("data_low_in", 8'h69, data_low_in)
  endtask

  task t_strobes_mode1;
    @(posedge clock);
    dram_area_mask <= 4'h1;
    area_16bit     <= 8'h04;
    pf_far         <= 8'h01;
    pf_far_en      <= 8'h01;
    wb(1'b1, OFS_CTRL, 8'h0E);
    `CHK("pf_oe bus", 8'hFE, pf_oe)
    `CHK("pf_out bus", strobes, pf_out[7:1])
    `CHK("wait", 1'b1, wait_request)
    `CHK("interrupt_request_15", strobes.lower_column_strobe, interrupt_request_15)
    `CHK("interrupt_request_14", strobes.upper_column_strobe, interrupt_request_14)
    @(posedge clock);
    area_16bit <= 8'h08;
    @(negedge clock);
    `CHK("cas 8bit", 2'b01, pf_oe[2:1])
    @(posedge clock);
    dram_area_mask <= 4'h0;
    wb(1'b1, OFS_CTRL, 8'h30);
    `CHK("pf_oe gpio", 8'hB0, pf_oe)
    `CHK("irq off", 2'b00, {interrupt_request_15, interrupt_request_14})
    `CHK("wait off", 1'b0, wait_request)
  endtask

  task t_mode7;
    @(posedge clock);
    pf_far     <= 8'h51;
    pf_far_en  <= 8'hF1;
    area_16bit <= 8'hFF;
    do_reset(3'h7);
    `CHK("pf_oe m7", 8'h00, pf_oe)
    wb(1'b1, OFS_PF_DIR, 8'h0F);
    wb(1'b1, OFS_PF_DATA, 8'h0A);
    wb(1'b1, OFS_PF_PIN, 8'hFF);
    wb(1'b0, OFS_PF_PIN, 8'h00);
    `CHK("pin read", 8'h5A, rd)
    `CHK("pf_oe m7 gpio", 8'h0F, pf_oe)
    wb(1'b1, OFS_PE_DIR, 8'hF0);
    `CHK("pe m7 gpio", 8'hF0, pe_oe)
    wb(1'b1, OFS_CTRL, 8'h09);
    `CHK("pe m7 bus", data_low_out, pe_out)
    `CHK("pf m7 nofsel", 8'h3F, pf_oe)
    `CHK("pf m7 data", 3'b010, pf_out[2:0])
    @(posedge clock);
    dram_area_mask <= 4'h1;
    wb(1'b1, OFS_FSEL, 8'h07);
    `CHK("cas fsel", {strobes.lower_column_strobe, strobes.upper_column_strobe}, pf_out[2:1])
    `CHK("pf fsel oe", 8'h3E, pf_oe)
    `CHK("wait fsel", 1'b1, wait_request)
  endtask

  initial begin
    t_reset_mode1;
    t_low_byte_mode1;
    t_strobes_mode1;
    t_mode7;
    close_out;
  end
endmodule
